/* mult16_core.sv */
// registered 16 x 16 multiplier with product registers and apb control
// assumes pin inputs are asynchronous and a host drives the apb bus
`timescale 1ns/100ps
`include "mult_cfg.svh"

module mult16_core
	import mult_pkg::*;
#(
	parameter int OPW = `OPERAND_W,
	parameter int DEPTH = `FIFO_DEPTH
)
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// operand pins
	input wire logic [OPW-1:0] x_data_in,
	// shared y / low half port
	input wire logic [OPW-1:0] y_port_in,
	output logic [OPW-1:0] y_port_out,
	output logic y_port_oe_n,
	// dedicated product port
	output logic [OPW-1:0] dedicated_port_out,
	output logic dedicated_port_oe_n,
	// independent-mode load strobes
	input wire logic x_reg_clock,
	input wire logic y_reg_clock,
	input wire logic high_half_clock,
	input wire logic low_half_clock,
	// single-mode load enables
	input wire logic x_load_en_n,
	input wire logic y_load_en_n,
	input wire logic product_load_en_n
);
	// refuse widths the product packing cannot serve
	if (OPW != `OPERAND_W)
	begin : g_bad_width
		$error("operand width must match the product layout");
	end

	// ==========================================
	// pin synchronisers
	localparam int NS = 2 * OPW + 7;
	// enables idle high, data and strobes idle low: reset shows no load
	localparam logic [NS-1:0] SYNC_IDLE = {{(NS-3){1'b0}}, 3'b111};
	logic [NS-1:0] pins_raw;  // all asynchronous pins
	logic [NS-1:0] s1_q;  // first stage, read by s2 only
	logic [NS-1:0] s2_q;  // second stage, safe to use
	logic [3:0] clk3_q;  // strobe delay for edges

	assign pins_raw = {x_data_in, y_port_in, x_reg_clock, y_reg_clock,
		high_half_clock, low_half_clock, x_load_en_n, y_load_en_n,
		product_load_en_n};

	// two flops per pin bit
	for (genvar i = 0; i < NS; i++)
	begin : g_sync
		always_ff @(posedge pclk or negedge presetn)
		begin
			if (!presetn)
			begin
				s1_q[i] <= SYNC_IDLE[i];
				s2_q[i] <= SYNC_IDLE[i];
			end
			else
			begin
				s1_q[i] <= pins_raw[i];
				s2_q[i] <= s1_q[i];
			end
		end
	end

	logic [OPW-1:0] x_s;  // synced x data
	logic [OPW-1:0] y_s;  // synced y data
	logic [3:0] clk_s;  // synced strobes x,y,hi,lo
	logic xe_n_s;
	logic ye_n_s;
	logic pe_n_s;

	assign x_s = s2_q[NS-1 -: OPW];
	assign y_s = s2_q[NS-1-OPW -: OPW];
	assign clk_s = s2_q[6:3];
	assign xe_n_s = s2_q[2];
	assign ye_n_s = s2_q[1];
	assign pe_n_s = s2_q[0];

	// third stage for rising-edge detection
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			clk3_q <= 4'h0;
		else
			clk3_q <= clk_s;
	end

	// ==========================================
	// control register and load events
	logic [`CTRL_W-1:0] ctrl_q;  // software control bits
	ctrl_t ctrl;
	logic [3:0] rise;  // strobe rising edges
	logic x_ld;
	logic y_ld;
	logic hi_ld;
	logic lo_ld;
	logic fifo_in_ready;  // back-pressure from buffer

	assign ctrl = ctrl_t'(ctrl_q);
	assign rise = clk_s & ~clk3_q;

	// strobe edges or low enables pick the load moments
	always_comb
	begin
		if (ctrl.indep_clocks)
		begin
			x_ld = rise[3];
			y_ld = rise[2];
			hi_ld = rise[1] && fifo_in_ready;
			lo_ld = rise[0] && fifo_in_ready;
		end
		else
		begin
			x_ld = !xe_n_s;
			y_ld = !ye_n_s;
			hi_ld = !pe_n_s && fifo_in_ready;
			lo_ld = !pe_n_s && fifo_in_ready;
		end
	end

	// ==========================================
	// input registers
	operand_t x_q;  // multiplicand with mode
	operand_t y_q;  // multiplier with mode
	logic rnd_q;  // latched round request

	// x register, holds unless loaded
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			x_q <= '0;
		else if (x_ld)
			x_q <= '{signed_mode: ctrl.x_signed_mode, data: x_s};
	end

	// y register, fed from the shared port
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			y_q <= '0;
		else if (y_ld)
			y_q <= '{signed_mode: ctrl.y_signed_mode, data: y_s};
	end

	// round register follows either operand load
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rnd_q <= 1'b0;
		else if (x_ld || y_ld)
			rnd_q <= ctrl.round_request;
	end

	// ==========================================
	// multiplier array and format adjust
	logic signed [OPW:0] xa;  // 17-bit extended operand
	logic signed [OPW:0] ya;
	logic signed [2*OPW+1:0] full;  // exact product
	logic [2*OPW-1:0] rounded;
	product_t prod_d;  // next product-register value

	// mode bit decides sign extension
	assign xa = {x_q.signed_mode & x_q.data[OPW-1], x_q.data};
	assign ya = {y_q.signed_mode & y_q.data[OPW-1], y_q.data};
	assign full = xa * ya;

	// round weight sits at the lsp top bit with format adjust, at lsp bit 14 below the sign copy without it
	always_comb
	begin
		if (ctrl.format_adjust)
			rounded = full[2*OPW-1:0] + {16'h0000, rnd_q, 15'h0000};
		else
			rounded = full[2*OPW-1:0] + {17'h0_0000, rnd_q, 14'h0000};
	end

	// full product or shifted product with sign copied into lsp
	always_comb
	begin
		if (ctrl.format_adjust)
			prod_d = rounded;
		else
			prod_d = {rounded[2*OPW-2:OPW-1], rounded[2*OPW-1],
				rounded[OPW-2:0]};
	end

	// ==========================================
	// product registers
	logic [OPW-1:0] hi_q;  // high product half
	logic [OPW-1:0] lo_q;  // low product half
	logic [OPW-1:0] hi_view;  // after feedthrough
	logic [OPW-1:0] lo_view;

	// high half loads on its own moment
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			hi_q <= '0;
		else if (hi_ld)
			hi_q <= prod_d.high_product_half;
	end

	// low half loads on its own moment
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			lo_q <= '0;
		else if (lo_ld)
			lo_q <= prod_d.low_product_half;
	end

	// feedthrough bypasses both registers
	assign hi_view = ctrl.product_feedthrough ? prod_d.high_product_half : hi_q;
	assign lo_view = ctrl.product_feedthrough ? prod_d.low_product_half : lo_q;

	// ==========================================
	// output ports
	// select high puts low half on both ports
	assign dedicated_port_out = ctrl.output_half_select ? lo_view : hi_view;
	assign y_port_out = lo_view;
	// enable high releases the shared port for y operands
	assign y_port_oe_n = ctrl.shared_port_out_en_n;
	assign dedicated_port_oe_n = ctrl.dedicated_port_out_en_n;

	// ==========================================
	// result buffer, pushed with each low-half load
	logic [31:0] fifo_out;
	logic fifo_out_valid;
	logic fifo_pop;
	logic [$clog2(DEPTH):0] fifo_count;

	word_fifo #(.WIDTH(32), .DEPTH(DEPTH)) u_fifo (
		.pclk(pclk),
		.presetn(presetn),
		.in_valid(lo_ld),
		.in_ready(fifo_in_ready),
		.in_data({hi_ld ? prod_d.high_product_half : hi_q, prod_d.low_product_half}),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_out),
		.count(fifo_count)
	);

	// ==========================================
	// apb slave
	logic acc;  // access phase
	logic known;  // mapped address

	// address match used by read and write paths
	function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
		hit = (a[11:2] == ofs[11:2]);
	endfunction

	assign acc = psel && penable;
	assign known = hit(paddr, `OFS_CTRL) || hit(paddr, `OFS_STATUS)
		|| hit(paddr, `OFS_PRODUCT) || hit(paddr, `OFS_RESULT);
	assign pready = 1'b1;
	assign pslverr = acc && !known;
	assign fifo_pop = acc && !pwrite && hit(paddr, `OFS_RESULT) && fifo_out_valid;

	// control register write
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ctrl_q <= `CTRL_W'(`CTRL_RESET);
		else if (acc && pwrite && hit(paddr, `OFS_CTRL))
			ctrl_q <= pwdata[`CTRL_W-1:0];
	end

	// read mux, zero for unmapped and write cycles
	always_comb
	begin
		prdata = 32'h0000_0000;
		if (acc && !pwrite)
		begin
			if (hit(paddr, `OFS_CTRL))
				prdata[`CTRL_W-1:0] = ctrl_q;
			else if (hit(paddr, `OFS_STATUS))
			begin
				prdata[`ST_EMPTY] = !fifo_out_valid;
				prdata[`ST_FULL] = !fifo_in_ready;
				prdata[`ST_COUNT_LSB +: $clog2(DEPTH)+1] = fifo_count;
			end
			else if (hit(paddr, `OFS_PRODUCT))
				prdata = {hi_view, lo_view};
			else if (hit(paddr, `OFS_RESULT) && fifo_out_valid)
				prdata = fifo_out;
		end
	end

	// ==========================================
	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	x_capture_a: assert property (x_ld |=> x_q == {$past(ctrl.x_signed_mode), $past(x_s)})
		else $error("x register missed its load");

	x_hold_a: assert property (!x_ld |=> $stable(x_q))
		else $error("x register changed while held");

	y_capture_a: assert property (y_ld |=> y_q.data == $past(y_s))
		else $error("y register missed its load");

	round_capture_a: assert property ((x_ld || y_ld) |=> rnd_q == $past(ctrl.round_request))
		else $error("round bit not captured");

	single_load_a: assert property (!ctrl.indep_clocks && !pe_n_s && fifo_in_ready
		|=> hi_q == $past(prod_d.high_product_half) && lo_q == $past(prod_d.low_product_half))
		else $error("product halves did not load together");

	indep_split_a: assert property (ctrl.indep_clocks && rise[1] && !rise[0] |=> $stable(lo_q))
		else $error("low half loaded on high half strobe");

	feed_view_a: assert property (ctrl.product_feedthrough && !ctrl.output_half_select
		|-> dedicated_port_out == prod_d.high_product_half)
		else $error("feedthrough not transparent");

	half_select_a: assert property (ctrl.output_half_select |-> dedicated_port_out == y_port_out)
		else $error("select high must show low half on both ports");

	shared_drive_a: assert property (!y_port_oe_n && !ctrl.product_feedthrough |-> y_port_out == lo_q)
		else $error("shared port not showing low half");

endmodule

/* mult_cfg.svh */
// offsets, field positions, reset values for the registered multiplier
// assumes a 32-bit apb bus with word-aligned registers
`ifndef MULT_CFG_SVH
`define MULT_CFG_SVH

// ==========================================
// register byte offsets
`define OFS_CTRL 12'h000
`define OFS_STATUS 12'h004
`define OFS_PRODUCT 12'h008
`define OFS_RESULT 12'h00C

// ==========================================
// control register fields
`define CTRL_W 9
`define CTRL_RESET 32'h0000_00C8

// ==========================================
// status register fields
`define ST_EMPTY 0
`define ST_FULL 1
`define ST_COUNT_LSB 8

// ==========================================
// sizes
`define OPERAND_W 16
`define FIFO_DEPTH 32

`endif

/* mult_pkg.sv */
// types shared by the multiplier and its result buffer
// assumes mult_cfg.svh for the widths
`include "mult_cfg.svh"

package mult_pkg;

	// ==========================================
	// control fields, msb first
	typedef struct packed {
		logic indep_clocks;
		logic dedicated_port_out_en_n;
		logic shared_port_out_en_n;
		logic output_half_select;
		logic round_request;
		logic format_adjust;
		logic product_feedthrough;
		logic y_signed_mode;
		logic x_signed_mode;
	} ctrl_t;

	// ==========================================
	// operand with its mode bit
	typedef struct packed {
		logic signed_mode;
		logic [`OPERAND_W-1:0] data;
	} operand_t;

	// ==========================================
	// one product, both halves
	typedef struct packed {
		logic [`OPERAND_W-1:0] high_product_half;
		logic [`OPERAND_W-1:0] low_product_half;
	} product_t;

endpackage

/* word_fifo.sv */
// small synchronous fifo with valid/ready on both sides
// assumes one clock and an asynchronous active-low reset
`timescale 1ns/100ps

module word_fifo
	import mult_pkg::*;
#(
	parameter int WIDTH = 32,
	parameter int DEPTH = 32
)
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	// fill level
	output logic [$clog2(DEPTH):0] count
);
	localparam int AW = $clog2(DEPTH);

	// refuse depths the pointer wrap cannot serve
	if (DEPTH < 2 || (1 << AW) != DEPTH)
	begin : g_bad_depth
		$error("fifo depth must be a power of two");
	end

	logic [WIDTH-1:0] mem [DEPTH];  // storage
	logic [AW-1:0] wr_q;  // write pointer
	logic [AW-1:0] rd_q;  // read pointer
	logic [AW:0] cnt_q;  // words held
	logic push;
	logic pop;

	assign in_ready = (cnt_q != DEPTH[AW:0]);
	assign out_valid = (cnt_q != '0);
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem[rd_q];
	assign count = cnt_q;

	// storage write, no reset needed
	always_ff @(posedge pclk)
	begin
		if (push)
			mem[wr_q] <= in_data;
	end

	// pointers and level
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end
		else
		begin
			if (push)
				wr_q <= wr_q + 1'b1;
			if (pop)
				rd_q <= rd_q + 1'b1;
			if (push && !pop)
				cnt_q <= cnt_q + 1'b1;
			else if (pop && !push)
				cnt_q <= cnt_q - 1'b1;
		end
	end

endmodule

/* mult_host_port.sv */
// host model on the shared y / low-half wire of the multiplier
// assumes the bench sets host_drive and host_value right after rising edges
`timescale 1ns/100ps

module mult_host_port
(
	// clock
	input wire logic pclk,
	// device side of the shared wire
	input wire logic [15:0] y_port_out,
	input wire logic y_port_oe_n,
	// host side
	input wire logic host_drive,
	input wire logic [15:0] host_value,
	// resolved wire level
	output logic [15:0] wire_level
);
	// last level seen, to show a changing pattern when nobody drives
	logic [15:0] last_q = 16'h0000;

	// ==========================================
	// wire resolution
	// contention shows as unknown, idle wire toggles every cycle
	always_comb
	begin
		if (!y_port_oe_n && host_drive)
			wire_level = 'x;
		else if (!y_port_oe_n)
			wire_level = y_port_out;
		else if (host_drive)
			wire_level = host_value;
		else
			wire_level = ~last_q;
	end

	// remember the level for the idle pattern
	always @(posedge pclk)
		last_q <= wire_level;
endmodule

/* registered_multiplier_16x16_bench.sv */
// self-checking bench for the registered multiplier with apb control
// assumes mult16_core, word_fifo and the host wire model are compiled first
`timescale 1ns/100ps
`include "mult_cfg.svh"

module registered_multiplier_16x16_bench;
	import mult_pkg::*;

	// ==========================================
	// design signals, all driven from time zero
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata;
	logic pready, pslverr, y_port_oe_n, dedicated_port_oe_n;
	logic [15:0] x_data_in = 16'h0000, y_port_in, y_port_out, dedicated_port_out;
	logic x_reg_clock = 0, y_reg_clock = 0, high_half_clock = 0, low_half_clock = 0;
	logic x_load_en_n = 1, y_load_en_n = 1, product_load_en_n = 1;
	logic host_drive = 0;
	logic [15:0] host_value = 16'h0000;
	int mismatches = 0, num_checks = 0;
	int seed = 32'hdae1;
	ctrl_t last_c;
	logic [15:0] last_x, last_y;

	// 20 MHz clock
	always #25 pclk = ~pclk;

	mult16_core u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .x_data_in, .y_port_in, .y_port_out,
		.y_port_oe_n, .dedicated_port_out, .dedicated_port_oe_n, .x_reg_clock,
		.y_reg_clock, .high_half_clock, .low_half_clock, .x_load_en_n,
		.y_load_en_n, .product_load_en_n);

	mult_host_port u_host (.pclk, .y_port_out, .y_port_oe_n, .host_drive,
		.host_value, .wire_level(y_port_in));

	// ==========================================
	// report and compare
	task automatic summarize;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wait_cyc(input int k);
		repeat (k) @(posedge pclk);
	endtask

	// ==========================================
	// apb master: setup, access until pready, then release
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20)
		begin
			mismatches++;
			summarize();
		end
	endtask

	// ==========================================
	// expected product words
	function automatic logic [31:0] expect_prod(logic [15:0] x, logic [15:0] y, ctrl_t c);
		logic signed [33:0] p;
		p = $signed({c.x_signed_mode & x[15], x}) * $signed({c.y_signed_mode & y[15], y});
		if (c.round_request)
			p = p + (c.format_adjust ? 34'sd32768 : 34'sd16384);
		if (c.format_adjust)
			return p[31:0];
		return {p[30:15], p[31], p[14:0]};
	endfunction

	// ==========================================
	// one multiply through pins, then ports and registers checked
	task automatic run_op(input logic [15:0] x, input logic [15:0] y, input ctrl_t c);
		logic [31:0] e, rd;
		logic err;
		ctrl_t c2;
		c.shared_port_out_en_n = 1'b1;
		c.dedicated_port_out_en_n = 1'b1;
		if (!(c.x_signed_mode && c.y_signed_mode))
			c.format_adjust = 1'b1;
		apb(1'b1, `OFS_CTRL, {23'h0, c}, rd, err);
		e = expect_prod(x, y, c);
		x_data_in <= x;
		host_drive <= 1'b1;
		host_value <= y;
		x_reg_clock <= c.indep_clocks;
		y_reg_clock <= c.indep_clocks;
		x_load_en_n <= c.indep_clocks;
		y_load_en_n <= c.indep_clocks;
		wait_cyc(4);
		x_reg_clock <= 1'b0;
		y_reg_clock <= 1'b0;
		x_load_en_n <= 1'b1;
		y_load_en_n <= 1'b1;
		wait_cyc(3);
		// operands must hold while the pins move on
		x_data_in <= ~x;
		host_drive <= 1'b0;
		if (!c.product_feedthrough)
		begin
			high_half_clock <= c.indep_clocks;
			low_half_clock <= c.indep_clocks;
			product_load_en_n <= c.indep_clocks;
			wait_cyc(1);
			high_half_clock <= 1'b0;
			low_half_clock <= 1'b0;
			product_load_en_n <= 1'b1;
		end
		wait_cyc(4);
		c2 = c;
		c2.output_half_select = 1'($random(seed));
		c2.shared_port_out_en_n = 1'($random(seed));
		c2.dedicated_port_out_en_n = 1'($random(seed));
		apb(1'b1, `OFS_CTRL, {23'h0, c2}, rd, err);
		apb(1'b0, `OFS_PRODUCT, 32'h0000_0000, rd, err);
		chk("product", e, rd);
		chk("dedicated", c2.output_half_select ? e[15:0] : e[31:16], dedicated_port_out);
		chk("shared", e[15:0], y_port_out);
		chk("shared oe", c2.shared_port_out_en_n, y_port_oe_n);
		chk("dedicated oe", c2.dedicated_port_out_en_n, dedicated_port_oe_n);
		if (!c.product_feedthrough)
		begin
			apb(1'b0, `OFS_RESULT, 32'h0000_0000, rd, err);
			chk("result", e, rd);
		end
		last_c = c;
		last_x = x;
		last_y = y;
	endtask

	// ==========================================
	// main sequence
	initial
	begin
		logic [31:0] rd, e;
		logic err;
		ctrl_t c;
		wait_cyc(2);
		presetn <= 1'b1;
		apb(1'b0, `OFS_CTRL, 32'h0000_0000, rd, err);
		chk("ctrl reset", 32'h0000_00C8, rd);
		repeat (4) apb(1'b0, `OFS_RESULT, 32'h0000_0000, rd, err);
		apb(1'b0, `OFS_STATUS, 32'h0000_0000, rd, err);
		chk("status empty", 32'h0000_0001, rd);
		apb(1'b0, 12'h010, 32'h0000_0000, rd, err);
		chk("unmapped err", 32'h0000_0001, {31'h0, err});
		chk("unmapped data", 32'h0000_0000, rd);
		// corner operands: extreme signed, unsigned and mixed
		run_op(16'h8000, 16'h8000, 9'h013);
		run_op(16'h8000, 16'h8000, 9'h103);
		run_op(16'hFFFF, 16'hFFFF, 9'h018);
		run_op(16'hFFFF, 16'h8000, 9'h109);
		// high-half strobe alone leaves the low half and the buffer untouched
		high_half_clock <= 1'b1;
		wait_cyc(1);
		high_half_clock <= 1'b0;
		wait_cyc(5);
		apb(1'b0, `OFS_STATUS, 32'h0000_0000, rd, err);
		chk("hi strobe alone", 32'h0000_0001, rd);
		repeat (14)
		begin
			c = ctrl_t'(9'($random(seed)));
			run_op(16'($random(seed)), 16'($random(seed)), c);
		end
		// fill the result buffer until it refuses, then drain it
		apb(1'b1, `OFS_CTRL, 32'h0000_00C8, rd, err);
		c = last_c;
		c.format_adjust = 1'b1;
		e = expect_prod(last_x, last_y, c);
		product_load_en_n <= 1'b0;
		wait_cyc(40);
		product_load_en_n <= 1'b1;
		wait_cyc(3);
		apb(1'b0, `OFS_STATUS, 32'h0000_0000, rd, err);
		chk("status full", 32'h0000_2002, rd);
		repeat (32)
		begin
			apb(1'b0, `OFS_RESULT, 32'h0000_0000, rd, err);
			chk("drained", e, rd);
		end
		apb(1'b0, `OFS_STATUS, 32'h0000_0000, rd, err);
		chk("status drained", 32'h0000_0001, rd);
		summarize();
	end
endmodule
